/* File: hdl/pioi_ctrl.sv */
// Purpose: Processor-side single-word I/O bus sequencer with shared interrupt.
// Assumes: Peripherals hold device_ready and input data steady until cleared.
// Notes:   Software drives one instruction at a time over APB.
`timescale 1ns/10ps
module pioi_ctrl #(
    parameter int WAIT_CYCLES = pioi_pkg::WAIT_CYC_DEFAULT
) (
    input  wire logic                    mclk_i,
    input  wire logic                    srst_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [pioi_pkg::AW-1:0] paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    input  wire logic [pioi_pkg::DW-1:0] input_bus_lines_i,
    input  wire logic                    device_ready_line_i,
    input  wire logic                    interrupt_request_line_i,
    output pioi_pkg::pioi_bus_t          io_bus_o,
    output logic      [pioi_pkg::DW-1:0] output_bus_lines_o,
    output pioi_pkg::pioi_strobe_t       strobe_o,
    output logic      [pioi_pkg::DW-1:0] trap_vec_o
);

    localparam int A_WAIT_LIM = WAIT_CYCLES + 4;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pioi_pkg::pioi_state_t       state_r;
    pioi_pkg::pioi_bus_t         bus_r;
    pioi_pkg::pioi_strobe_t      strobe_r;
    logic [pioi_pkg::DW-1:0]     acc_r;
    logic [pioi_pkg::DW-1:0]     instr_r;
    logic [pioi_pkg::DW-1:0]     obus_r;
    logic [15:0]                 cnt_r;
    logic                        skip_r;
    logic                        tmo_r;
    logic                        done_r;
    logic                        taken_r;
    logic                        inten_r;
    logic                        clear_r;
    logic [31:0]                 prdata_r;
    logic                        pslverr_r;
    logic [pioi_pkg::SYNC_W-1:0] sync_q;
    logic [pioi_pkg::DW-1:0]     in_s;
    logic                        rdy_s;
    logic                        irq_s;
    logic                        wr_en;
    logic                        setup_ph;
    logic                        addr_ok;
    logic                        start;
    logic                        setup_end;
    logic                        accept;
    logic                        timeout;
    logic                        take_irq;
    logic                        is_mask;
    pioi_pkg::pioi_kind_t        wkind;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pioi_sync #(
        .W (pioi_pkg::SYNC_W)
    ) u_sync (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .d_i    ({interrupt_request_line_i, device_ready_line_i, input_bus_lines_i}),
        .q_o    (sync_q)
    );

    // Upper lines from a character peripheral arrive as zero and OR harmlessly
    assign in_s  = sync_q[pioi_pkg::DW-1:0];
    assign rdy_s = sync_q[pioi_pkg::DW];
    assign irq_s = sync_q[pioi_pkg::DW+1];  // single wired-OR request, already masked per source

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign wr_en    = psel_i && penable_i && pwrite_i && addr_ok;
    assign setup_ph = psel_i && !penable_i;
    assign addr_ok  = (paddr_i == pioi_pkg::ADDR_CTRL) || (paddr_i == pioi_pkg::ADDR_INSTR) ||
                      (paddr_i == pioi_pkg::ADDR_ACC)  || (paddr_i == pioi_pkg::ADDR_STATUS);
    assign wkind    = pioi_pkg::pioi_kind_t'(pwdata_i[pioi_pkg::CTRL_KIND_LSB +: 2]);
    assign start    = wr_en && (paddr_i == pioi_pkg::ADDR_CTRL) && pwdata_i[pioi_pkg::CTRL_START_BIT] &&
                      (state_r == pioi_pkg::ST_IDLE);
    // Only the full code selects the mask path; other bits go untouched to the bus
    assign is_mask  = (wkind == pioi_pkg::KIND_OUTPUT_FROM_ACCUMULATOR) &&
                      (instr_r[pioi_pkg::CODE_W-1:0] == pioi_pkg::MASK_CODE);

    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r;

    // Read data is captured in the setup phase so it comes from a flop
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= !addr_ok;
            prdata_r  <= 32'h0000_0000;
            unique case (paddr_i)
                pioi_pkg::ADDR_INSTR:  prdata_r[pioi_pkg::DW-1:0] <= instr_r;
                pioi_pkg::ADDR_ACC:    prdata_r[pioi_pkg::DW-1:0] <= acc_r;
                pioi_pkg::ADDR_STATUS: begin
                    prdata_r[pioi_pkg::ST_BUSY_BIT]    <= (state_r != pioi_pkg::ST_IDLE);
                    prdata_r[pioi_pkg::ST_DONE_BIT]    <= done_r;
                    prdata_r[pioi_pkg::ST_SKIP_BIT]    <= skip_r;
                    prdata_r[pioi_pkg::ST_TMO_BIT]     <= tmo_r;
                    prdata_r[pioi_pkg::ST_INTLINE_BIT] <= irq_s;
                    prdata_r[pioi_pkg::ST_INTEN_BIT]   <= inten_r;
                    prdata_r[pioi_pkg::ST_TAKEN_BIT]   <= taken_r;
                end
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            instr_r <= pioi_pkg::INSTR_RST;
        end else if (wr_en && (paddr_i == pioi_pkg::ADDR_INSTR) && (state_r == pioi_pkg::ST_IDLE)) begin
            instr_r <= pwdata_i[pioi_pkg::DW-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign setup_end = (state_r == pioi_pkg::ST_SETUP) && (cnt_r == 16'(pioi_pkg::CTL_SETUP_CYC - 1));
    assign accept    = (state_r == pioi_pkg::ST_WAIT) && rdy_s;
    assign timeout   = (state_r == pioi_pkg::ST_WAIT) && !rdy_s && (cnt_r == 16'(WAIT_CYCLES - 1));

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_r <= pioi_pkg::ST_IDLE;
            cnt_r   <= 16'h0000;
        end else begin
            unique case (state_r)
                pioi_pkg::ST_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (start) begin
                        state_r <= pioi_pkg::ST_SETUP;
                    end
                end
                pioi_pkg::ST_SETUP: begin
                    // Codes settle before ready is looked at, so a stale ready is not taken
                    if (setup_end) begin
                        cnt_r <= 16'h0000;
                        if ((bus_r.kind == pioi_pkg::KIND_CONTROL_PULSE_INSTRUCTION) || !bus_r.active) begin
                            state_r <= pioi_pkg::ST_FINISH;
                        end else begin
                            state_r <= pioi_pkg::ST_WAIT;
                        end
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                pioi_pkg::ST_WAIT: begin
                    if (accept || timeout) begin
                        state_r <= pioi_pkg::ST_FINISH;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                pioi_pkg::ST_FINISH: begin
                    state_r <= pioi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Bus codes and output data are held for the whole instruction
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bus_r   <= '0;
            obus_r  <= pioi_pkg::ACC_RST;
            clear_r <= 1'b0;
        end else if (start) begin
            bus_r.active <= !is_mask;  // mask update carries no device address
            bus_r.kind   <= wkind;
            bus_r.fn     <= is_mask ? '0 : instr_r[pioi_pkg::FN_LSB +: pioi_pkg::FN_W];
            bus_r.dev    <= is_mask ? '0 : instr_r[pioi_pkg::DEV_LSB +: pioi_pkg::DEV_W];
            clear_r      <= instr_r[pioi_pkg::CLEAR_BIT];
            obus_r       <= (wkind == pioi_pkg::KIND_OUTPUT_FROM_ACCUMULATOR) ? acc_r : '0;
        end else if (state_r == pioi_pkg::ST_FINISH) begin
            bus_r  <= '0;
            obus_r <= '0;
        end
    end

    // Strobes are one-cycle pulses
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            strobe_r <= '0;
        end else begin
            strobe_r                         <= '0;
            strobe_r.control_pulse           <= setup_end && bus_r.active &&
                                                (bus_r.kind == pioi_pkg::KIND_CONTROL_PULSE_INSTRUCTION);
            strobe_r.mask_load_strobe        <= setup_end && !bus_r.active;
            strobe_r.ready_clear_line        <= accept && (bus_r.kind == pioi_pkg::KIND_INPUT_TO_ACCUMULATOR);
            strobe_r.out_strobe              <= accept && (bus_r.kind == pioi_pkg::KIND_OUTPUT_FROM_ACCUMULATOR);
            strobe_r.jump_and_store_location <= take_irq;
        end
    end

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_r <= pioi_pkg::ACC_RST;
        end else if (accept && (bus_r.kind == pioi_pkg::KIND_INPUT_TO_ACCUMULATOR)) begin
            acc_r <= (clear_r ? pioi_pkg::ACC_RST : acc_r) | in_s;
        end else if (wr_en && (paddr_i == pioi_pkg::ADDR_ACC) && (state_r == pioi_pkg::ST_IDLE)) begin
            acc_r <= pwdata_i[pioi_pkg::DW-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Status flags: hardware set wins over software clear
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            skip_r <= 1'b0;
            tmo_r  <= 1'b0;
        end else if (start) begin
            skip_r <= 1'b0;
            tmo_r  <= 1'b0;
        end else if (accept) begin
            skip_r <= 1'b1;
        end else if (timeout) begin
            tmo_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            done_r <= 1'b0;
        end else if (state_r == pioi_pkg::ST_FINISH) begin
            done_r <= 1'b1;
        end else if (wr_en && (paddr_i == pioi_pkg::ADDR_STATUS) && pwdata_i[pioi_pkg::ST_DONE_BIT]) begin
            done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt entry
    // ------------------------------------------------------------------
    assign take_irq = inten_r && irq_s && (state_r == pioi_pkg::ST_IDLE) && !start;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            inten_r <= 1'b0;
        end else if (take_irq) begin
            inten_r <= 1'b0;
        end else if (wr_en && (paddr_i == pioi_pkg::ADDR_CTRL)) begin
            inten_r <= pwdata_i[pioi_pkg::CTRL_INTEN_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            taken_r <= 1'b0;
        end else if (take_irq) begin
            taken_r <= 1'b1;
        end else if (wr_en && (paddr_i == pioi_pkg::ADDR_STATUS) && pwdata_i[pioi_pkg::ST_TAKEN_BIT]) begin
            taken_r <= 1'b0;
        end
    end

    assign io_bus_o           = bus_r;
    assign output_bus_lines_o = obus_r;
    assign strobe_o           = strobe_r;
    assign trap_vec_o         = pioi_pkg::TRAP_VEC;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_in_accept;
        accept && (bus_r.kind == pioi_pkg::KIND_INPUT_TO_ACCUMULATOR);
    endsequence

    sequence s_wait_start;
        $rose(state_r == pioi_pkg::ST_WAIT);
    endsequence

    a_codes_held: assert property (@(posedge mclk_i) disable iff (srst_i)
        (state_r != pioi_pkg::ST_IDLE) && $past(state_r != pioi_pkg::ST_IDLE) |-> $stable(bus_r))
        else $error("bus codes changed during an instruction");

    a_input_or: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_in_accept |=> acc_r == (($past(clear_r) ? '0 : $past(acc_r)) | $past(in_s)))
        else $error("input did not OR into accumulator");

    a_ready_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_in_accept |=> strobe_r.ready_clear_line ##1 !strobe_r.ready_clear_line)
        else $error("ready clear pulse missing or long");

    a_tmo_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
        timeout |=> $stable(acc_r) && !skip_r && !strobe_r.out_strobe && !strobe_r.ready_clear_line)
        else $error("timeout changed accumulator or skipped");

    a_out_strobe: assert property (@(posedge mclk_i) disable iff (srst_i)
        strobe_r.out_strobe |-> skip_r && (output_bus_lines_o == acc_r) && bus_r.active)
        else $error("output strobe without skip or data");

    a_ctl_delay: assert property (@(posedge mclk_i) disable iff (srst_i)
        strobe_r.control_pulse |-> $past(bus_r.active, 3) && !skip_r)
        else $error("control pulse before codes settled");

    a_ctl_noskip: assert property (@(posedge mclk_i) disable iff (srst_i)
        (state_r == pioi_pkg::ST_SETUP) && (bus_r.kind == pioi_pkg::KIND_CONTROL_PULSE_INSTRUCTION)
        |-> ##[1:8] (state_r == pioi_pkg::ST_FINISH) && !skip_r)
        else $error("control instruction waited or skipped");

    a_wait_bound: assert property (@(posedge mclk_i) disable iff (srst_i)
        s_wait_start |-> ##[1:A_WAIT_LIM] (state_r == pioi_pkg::ST_FINISH))
        else $error("ready wait not bounded");

    a_mask_load: assert property (@(posedge mclk_i) disable iff (srst_i)
        strobe_r.mask_load_strobe |-> !bus_r.active && (output_bus_lines_o == acc_r))
        else $error("mask strobe with device address or wrong data");

    a_irq_entry: assert property (@(posedge mclk_i) disable iff (srst_i)
        take_irq |=> strobe_r.jump_and_store_location && !inten_r ##1 !strobe_r.jump_and_store_location)
        else $error("interrupt entry did not disable interrupts");

endmodule

/* File: hdl/pioi_pkg.sv */
// Purpose: Shared constants and types for the programmed I/O bus controller.
// Assumes: 10 MHz mclk_i; word bit 1 of the bus is the MSB (index 15).
// Notes:   Register offsets are byte addresses on a 32-bit APB.
package pioi_pkg;

    // ------------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------------
    localparam int DW               = 16;
    localparam int AW               = 8;
    localparam int CLK_PERIOD_NS    = 100;
    localparam int CTL_SETUP_NS     = 300;
    localparam int CTL_SETUP_CYC    = (CTL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC_DEFAULT = 16;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [AW-1:0] ADDR_INSTR  = 8'h04;
    localparam logic [AW-1:0] ADDR_ACC    = 8'h08;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h0C;

    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_KIND_LSB  = 1;
    localparam int CTRL_INTEN_BIT = 3;

    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_DONE_BIT    = 1;
    localparam int ST_SKIP_BIT    = 2;
    localparam int ST_TMO_BIT     = 3;
    localparam int ST_INTLINE_BIT = 4;
    localparam int ST_INTEN_BIT   = 5;
    localparam int ST_TAKEN_BIT   = 6;

    // ------------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------------
    localparam int DEV_LSB   = 0;
    localparam int DEV_W     = 6;
    localparam int FN_LSB    = 6;
    localparam int FN_W      = 4;
    localparam int CLEAR_BIT = 9;
    localparam int CODE_W    = DEV_W + FN_W;

    localparam logic [CODE_W-1:0] MASK_CODE = 10'h010;
    localparam logic [DW-1:0]     TRAP_VEC  = 16'h0018;
    localparam logic [DW-1:0]     ACC_RST   = 16'h0000;
    localparam logic [DW-1:0]     INSTR_RST = 16'h0000;

    typedef enum logic [1:0] {
        KIND_INPUT_TO_ACCUMULATOR     = 2'h0,
        KIND_OUTPUT_FROM_ACCUMULATOR  = 2'h1,
        KIND_CONTROL_PULSE_INSTRUCTION = 2'h2,
        KIND_SENSE_AND_SKIP           = 2'h3
    } pioi_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETUP  = 2'b01,
        ST_WAIT   = 2'b11,
        ST_FINISH = 2'b10
    } pioi_state_t;

    typedef struct packed {
        logic             active;
        pioi_kind_t       kind;
        logic [FN_W-1:0]  fn;
        logic [DEV_W-1:0] dev;
    } pioi_bus_t;

    typedef struct packed {
        logic ready_clear_line;
        logic out_strobe;
        logic control_pulse;
        logic mask_load_strobe;
        logic jump_and_store_location;
    } pioi_strobe_t;

    localparam int SYNC_W = DW + 2;

endpackage

/* File: hdl/pioi_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/10ps
module pioi_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;

endmodule

/* File: testbench/pioi_periph.sv */
// Purpose: Peripheral controller model on the shared I/O bus.
// Assumes: One device code; mask bit index 0 is bus bit 16.
// Notes:   Ready drops after the clear pulse; undriven input lines stay zero.
`timescale 1ns/10ps
module pioi_periph #(
    parameter logic [5:0] DEV      = 6'h2A,
    parameter int         MASK_IDX = 0
) (
    input  wire logic                   mclk_i,
    input  wire pioi_pkg::pioi_bus_t    io_bus_i,
    input  wire logic [15:0]            out_bus_i,
    input  wire pioi_pkg::pioi_strobe_t strobe_i,
    input  wire logic                   ready_en_i,
    input  wire logic                   irq_pend_i,
    input  wire logic [15:0]            data_i,
    output logic      [15:0]            in_bus_o,
    output logic                        ready_o,
    output logic                        irq_o,
    output logic      [15:0]            cap_o
);
    logic clr_r  = 1'b0;
    logic mask_r = 1'b0;
    logic sel;
    logic sense_irq;
    assign sel       = io_bus_i.active && io_bus_i.dev == DEV;
    assign sense_irq = io_bus_i.kind == pioi_pkg::KIND_SENSE_AND_SKIP && io_bus_i.fn == 4'h1;
    // Character device: high lines left at zero
    assign in_bus_o  = (sel && io_bus_i.kind == pioi_pkg::KIND_INPUT_TO_ACCUMULATOR) ? {8'h00, data_i[7:0]} : 16'h0000;
    // Pending request on ready when sensed
    assign ready_o   = sense_irq ? (sel && irq_pend_i) : (sel && ready_en_i && !clr_r);
    assign irq_o     = irq_pend_i && mask_r;
    always_ff @(posedge mclk_i) begin
        clr_r <= sel && (clr_r || strobe_i.ready_clear_line);
        if (strobe_i.out_strobe) cap_o <= out_bus_i;
        if (strobe_i.mask_load_strobe) mask_r <= out_bus_i[MASK_IDX];
    end
endmodule

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the I/O bus sequencer.
// Assumes: WAIT_CYCLES set to 4 to keep runs short.
// Notes:   Reads note their expected value; a monitor compares at the access edge.
`timescale 1ns/10ps
module tb;
    localparam logic [5:0] DEV  = 6'h2A;
    localparam logic [1:0] K_IN = pioi_pkg::KIND_INPUT_TO_ACCUMULATOR;
    localparam logic [1:0] K_OT = pioi_pkg::KIND_OUTPUT_FROM_ACCUMULATOR;
    localparam logic [1:0] K_CP = pioi_pkg::KIND_CONTROL_PULSE_INSTRUCTION;
    localparam logic [1:0] K_SK = pioi_pkg::KIND_SENSE_AND_SKIP;
    localparam logic [7:0] A_AC = pioi_pkg::ADDR_ACC;
    localparam logic [7:0] A_ST = pioi_pkg::ADDR_STATUS;
    logic mclk_i = 1'b0, srst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rd_chk = 1'b0;
    logic ready_en = 1'b0, irq_pend = 1'b0, pready_o, pslverr_o, dev_rdy, irq_line;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_o, q;
    logic [15:0] in_bus, out_bus, trap_vec, cap, a, data = 16'h0000;
    logic [4:0]  stb_seen = 5'h00;
    pioi_pkg::pioi_bus_t    io_bus;
    pioi_pkg::pioi_strobe_t stb_o;
    logic [31:0] expq[$];
    int mismatches = 0, n_tests = 0, cyc = 0;
    always #50 mclk_i = ~mclk_i;
    pioi_ctrl #(.WAIT_CYCLES(4)) i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .input_bus_lines_i(in_bus), .device_ready_line_i(dev_rdy),
        .interrupt_request_line_i(irq_line), .io_bus_o(io_bus), .output_bus_lines_o(out_bus),
        .strobe_o(stb_o), .trap_vec_o(trap_vec));
    pioi_periph #(.DEV(DEV), .MASK_IDX(0)) i_dev (.mclk_i(mclk_i), .io_bus_i(io_bus), .out_bus_i(out_bus),
        .strobe_i(stb_o), .ready_en_i(ready_en), .irq_pend_i(irq_pend), .data_i(data), .in_bus_o(in_bus),
        .ready_o(dev_rdy), .irq_o(irq_line), .cap_o(cap));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic c);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        rd_chk <= c;
        if (c) expq.push_back(d);
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        psel <= 1'b0;
        penable <= 1'b0;
        rd_chk <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Start one instruction, wait for idle, then check status and strobes seen
    task automatic run(input logic [1:0] k, input logic [9:0] ins, input logic [31:0] st, input logic [4:0] sb);
        apb(1'b1, pioi_pkg::ADDR_INSTR, {22'h0, ins}, 1'b0);
        apb(1'b1, pioi_pkg::ADDR_CTRL, {29'h0, k, 1'b1}, 1'b0);
        do apb(1'b0, A_ST, 32'h0, 1'b0); while (q[pioi_pkg::ST_BUSY_BIT] !== 1'b0);
        repeat (4) @(posedge mclk_i);
        apb(1'b0, A_ST, st, 1'b1);
        check({27'h0, stb_seen}, {27'h0, sb});
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 8000) begin
            mismatches++;
            conclude();
        end
    end
    // ------------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (psel && penable && pready_o && rd_chk) check(prdata_o, expq.pop_front());
        if (psel && penable && pwrite && paddr == pioi_pkg::ADDR_CTRL) stb_seen <= 5'h00;
        else stb_seen <= stb_seen | stb_o;
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(58424));
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        check({16'h0, trap_vec}, 32'h18);
        apb(1'b0, A_AC, 32'h0, 1'b1);
        apb(1'b0, A_ST, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        check({31'h0, pslverr_o}, 32'h1);
        a = 16'($urandom);
        data <= 16'($urandom);
        ready_en <= 1'b1;
        apb(1'b1, A_AC, {16'h0, a}, 1'b0);
        run(K_IN, {4'h7, DEV}, 32'h06, 5'b10000);
        a = a | {8'h00, data[7:0]};
        apb(1'b0, A_AC, {16'h0, a}, 1'b1);
        run(K_IN, {4'h8, DEV}, 32'h06, 5'b10000);
        a = {8'h00, data[7:0]};
        apb(1'b0, A_AC, {16'h0, a}, 1'b1);
        data <= 16'($urandom);
        run(K_IN, {4'h0, ~DEV}, 32'h0A, 5'b00000);
        apb(1'b0, A_AC, {16'h0, a}, 1'b1);
        a = 16'($urandom);
        apb(1'b1, A_AC, {16'h0, a}, 1'b0);
        run(K_OT, {4'h5, DEV}, 32'h06, 5'b01000);
        check({16'h0, cap}, {16'h0, a});
        ready_en <= 1'b0;
        apb(1'b1, A_AC, {16'h0, ~a}, 1'b0);
        run(K_OT, {4'h5, DEV}, 32'h0A, 5'b00000);
        check({16'h0, cap}, {16'h0, a});
        ready_en <= 1'b1;
        run(K_CP, {4'h3, DEV}, 32'h02, 5'b00100);
        run(K_SK, {4'h0, DEV}, 32'h06, 5'b00000);
        ready_en <= 1'b0;
        run(K_SK, {4'h0, DEV}, 32'h0A, 5'b00000);
        irq_pend <= 1'b1;
        run(K_SK, {4'h1, DEV}, 32'h06, 5'b00000);
        apb(1'b1, A_AC, 32'h1, 1'b0);
        run(K_OT, 10'h010, 32'h12, 5'b00010);
        apb(1'b1, pioi_pkg::ADDR_CTRL, 32'h8, 1'b0);
        repeat (3) @(posedge mclk_i);
        apb(1'b0, A_ST, 32'h52, 1'b1);
        check({27'h0, stb_seen}, 32'h1);
        // Clearing done and taken leaves only the live request line
        apb(1'b1, A_ST, 32'h42, 1'b0);
        apb(1'b0, A_ST, 32'h10, 1'b1);
        conclude();
    end
endmodule
